// >>> bench/tb_top.sv
// tb_top: directed checks of the up/down counter through its pins and register bus.
// assumes ce stays high; count clock bursts come from udc_ctl_model.
`timescale 1ns/1ps

module tb_top;
  import udc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, start = 1'b0;
  logic en_n = 1'b1, dir = 1'b0, ld_n = 1'b1, count_clk, busy;
  logic [3:0] ld_d = 4'h0;
  logic [4:0] pulses = 5'h00;
  logic [31:0] rd;
  logic [1:0] rr;
  udc_pins_s pins;
  udc_axil_req_s axi_req = '0;
  udc_axil_rsp_s axi_rsp;
  udc_out_s cnt_out;
  int err_total = 0, tests_run = 0, cyc = 0;
  assign pins = {count_clk, en_n, dir, ld_n, ld_d};
  udc_counter dut_u (.aclk, .aresetn, .ce, .pins, .axi_req, .axi_rsp, .cnt_out);
  udc_ctl_model ctl_u (.aclk, .aresetn, .start, .pulses, .count_clk, .busy);
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      conclude();
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic burst(input logic [4:0] n);
    start <= 1'b1;
    pulses <= n;
    @(posedge aclk);
    start <= 1'b0;
    do @(posedge aclk); while (busy);
    repeat (5) @(posedge aclk);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while ((axi_req.awvalid && !axi_rsp.awready) || (axi_req.wvalid && !axi_rsp.wready));
    do @(posedge aclk); while (!axi_rsp.bvalid);
    axi_req.bready <= 1'b0;
    rr = axi_rsp.bresp;
  endtask
  task automatic axr(input logic [7:0] a);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    do @(posedge aclk); while (!axi_rsp.arready);
    axi_req.arvalid <= 1'b0;
    do @(posedge aclk); while (!axi_rsp.rvalid);
    axi_req.rready <= 1'b0;
    rd = axi_rsp.rdata;
    rr = axi_rsp.rresp;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence: preset 13, up through 15, inhibit, down through 0
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    ld_d <= 4'hd;
    ld_n <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(cnt_out.count, 34'hd);
    burst(5'h2);
    chk(cnt_out.count, 34'hd);
    ld_n <= 1'b1;
    en_n <= 1'b0;
    burst(5'h2);
    chk({cnt_out.max_min, cnt_out.ripple_strobe_n, cnt_out.count}, 34'h2f);
    burst(5'h3);
    chk(cnt_out.count, 34'h2);
    en_n <= 1'b1;
    burst(5'h2);
    chk(cnt_out.count, 34'h2);
    $display("up and inhibit test done");
    dir <= 1'b1;
    en_n <= 1'b0;
    burst(5'h2);
    chk({cnt_out.max_min, cnt_out.ripple_strobe_n, cnt_out.count}, 34'h20);
    en_n <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(cnt_out.ripple_strobe_n, 34'h1);
    en_n <= 1'b0;
    burst(5'h3);
    chk(cnt_out.count, 34'hd);
    $display("down test done");
    axr(ADDR_STATUS);
    chk({rr, rd}, {RESP_OKAY, 32'h6d});
    axw(ADDR_CTRL, 32'h1);
    burst(5'h1);
    chk(cnt_out.count, 34'hd);
    axr(ADDR_CTRL);
    chk({rr, rd}, {RESP_OKAY, 32'h1});
    axw(ADDR_CTRL, 32'h32);
    repeat (2) @(posedge aclk);
    chk({rr, 28'h0, cnt_out.count}, {RESP_OKAY, 32'h3});
    axr(8'h08);
    chk({rr, rd}, {RESP_SLVERR, 32'h0});
    $display("register test done");
    conclude();
  end
endmodule

bind udc_counter udc_properties chk_u (.aclk, .aresetn, .pins, .axi_rsp, .cnt_out);

// >>> bench/udc_ctl_model.sv
// udc_ctl_model: controlling logic that clocks the counter pin in bursts.
// assumes start lasts one cycle; the pin rests low between bursts.
`timescale 1ns/1ps

module udc_ctl_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [4:0] pulses,
  output logic count_clk,
  output logic busy
);
  logic [5:0] left_r;
  logic [2:0] div_r;
  // six cycles per level, so the synchroniser never drops one
  assign busy = left_r != 6'h00;
  assign count_clk = left_r[0];
  always_ff @(posedge aclk) begin
    if (!aresetn || start) begin
      left_r <= aresetn ? {pulses, 1'b0} : 6'h00;
      div_r <= 3'h0;
    end else if (busy) begin
      div_r <= (div_r == 3'h5) ? 3'h0 : div_r + 3'h1;
      left_r <= (div_r == 3'h5) ? left_r - 6'h01 : left_r;
    end
  end
endmodule

// >>> bench/udc_properties.sv
// udc_properties: timing relations of the count, terminal flag and ripple strobe outputs.
// assumes a bind onto udc_counter with ce held high.
`timescale 1ns/1ps

module udc_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire udc_pkg::udc_pins_s pins,
  input wire udc_pkg::udc_axil_rsp_s axi_rsp,
  input wire udc_pkg::udc_out_s cnt_out
);
  import udc_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // checks; five-cycle windows absorb the pin synchroniser lag
  // ------------------------------------------------------------
  AST_HOLD_OFF: assert property (
    (pins.count_enable_n && pins.load_n && !axi_rsp.bvalid)[*5] |-> $stable(cnt_out.count)) else $error("moved");
  AST_LOAD: assert property (
    (!pins.load_n && $stable(pins.load_data))[*5] |-> cnt_out.count == pins.load_data) else $error("load");
  AST_TOP: assert property (
    (cnt_out.count == CNT_MAX && !pins.direction)[*5] |-> cnt_out.max_min) else $error("top");
  AST_BOTTOM: assert property (
    (cnt_out.count == CNT_MIN && pins.direction)[*5] |-> cnt_out.max_min) else $error("bottom");
  AST_MID: assert property (
    cnt_out.count != CNT_MAX && cnt_out.count != CNT_MIN |-> !cnt_out.max_min) else $error("mid");
  AST_RIP_EN: assert property (
    pins.count_enable_n[*5] |-> cnt_out.ripple_strobe_n) else $error("rip en");
  AST_RIP_CLK: assert property (
    pins.count_clk[*5] |-> cnt_out.ripple_strobe_n) else $error("rip clk");
  AST_STEP: assert property (
    (pins.load_n && $stable(pins.direction) && !axi_rsp.bvalid)[*5] ##0 $changed(cnt_out.count) |->
    cnt_out.count == (pins.direction ? $past(cnt_out.count) - CNT_ONE : $past(cnt_out.count) + CNT_ONE))
    else $error("step");
  CV_TERM: cover property ($rose(cnt_out.max_min));
  CV_RIP: cover property ($fell(cnt_out.ripple_strobe_n));
  CV_LOAD: cover property ($fell(pins.load_n));
endmodule

// >>> common/udc_pkg.sv
// udc_pkg: constants, register map and carrier structs of the 4-bit up/down counter.
// assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
package udc_pkg;

  // --------------------------------------------------------------
  // counter geometry
  // --------------------------------------------------------------
  localparam int CNT_W = 4;
  localparam logic [3:0] CNT_MAX = 4'hf;
  localparam logic [3:0] CNT_MIN = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_RST = 4'h0;

  // --------------------------------------------------------------
  // register map, byte addresses
  // --------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int CTRL_LOAD_BIT = 1;
  localparam int CTRL_VAL_LSB = 4;
  localparam int ST_TERM_BIT = 4;
  localparam int ST_RIPPLE_BIT = 5;
  localparam int ST_DIR_BIT = 6;
  localparam int ST_CEN_BIT = 7;
  localparam int ST_HOLD_BIT = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // --------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } udc_axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } udc_axil_rsp_s;

  typedef struct packed {
    logic count_clk;
    logic count_enable_n;
    logic direction;
    logic load_n;
    logic [3:0] load_data;
  } udc_pins_s;

  typedef struct packed {
    logic [3:0] count;
    logic max_min;
    logic ripple_strobe_n;
  } udc_out_s;

endpackage

// >>> verilog/udc_counter.sv
// udc_counter: 4-bit synchronous up/down counter with preset, terminal flag and ripple strobe,
// plus an AXI4-Lite slave for software hold, software preset and status.
// assumes all pin inputs are asynchronous to aclk; aclk far faster than the count clock pin.
//
// Function
// - the four count bits are one register that changes as a whole on one edge.
// - the count moves only on a rising count clock edge while count enable is low.
// - with count enable high the count stays put across count clock edges.
// - direction low counts up and direction high counts down.
// - enable and direction take effect only when sampled at a count clock edge; here only for the count, as the flag and strobe follow them at once.
// - a low load pin forces the count to the parallel data, whatever the count clock does.
// - counting up from 15 gives 0.
// - counting down from 0 gives 15.
// - the terminal flag is high while the count is 0 counting down or 15 counting up.
// - the ripple strobe goes low on the same terminal state, only while the count clock and count enable are both low.
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps

module udc_counter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire udc_pkg::udc_pins_s pins,
  input wire udc_pkg::udc_axil_req_s axi_req,
  output udc_pkg::udc_axil_rsp_s axi_rsp,
  output udc_pkg::udc_out_s cnt_out
);
  import udc_pkg::*;

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    udc_pins_s sync1;
    udc_pins_s sync2;
    logic clk_prev;
    logic [3:0] count;
    logic hold;
    logic aw_done;
    logic w_done;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    udc_axil_rsp_s rsp;
    udc_out_s out;
  } udc_state_s;

  localparam udc_state_s ST_RST = '{
    sync1: '{count_clk: 1'b0, count_enable_n: 1'b1, direction: 1'b0, load_n: 1'b1, load_data: CNT_RST},
    sync2: '{count_clk: 1'b0, count_enable_n: 1'b1, direction: 1'b0, load_n: 1'b1, load_data: CNT_RST},
    clk_prev: 1'b0,
    count: CNT_RST,
    hold: 1'b0,
    aw_done: 1'b0,
    w_done: 1'b0,
    waddr: 8'h00,
    wdata: 32'h0000_0000,
    wstrb: 4'h0,
    rsp: '{awready: 1'b1, wready: 1'b1, bresp: RESP_OKAY, bvalid: 1'b0,
           arready: 1'b1, rdata: 32'h0000_0000, rresp: RESP_OKAY, rvalid: 1'b0},
    out: '{count: CNT_RST, max_min: 1'b0, ripple_strobe_n: 1'b1}
  };

  udc_state_s st_r;
  udc_state_s st_nxt;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic term_hit(input logic [3:0] c, input logic down);
    term_hit = down ? (c == CNT_MIN) : (c == CNT_MAX);
  endfunction

  function automatic logic [31:0] status_word(input udc_state_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CNT_W-1:0] = s.out.count;
    w[ST_TERM_BIT] = s.out.max_min;
    w[ST_RIPPLE_BIT] = s.out.ripple_strobe_n;
    w[ST_DIR_BIT] = s.sync2.direction;
    w[ST_CEN_BIT] = s.sync2.count_enable_n;
    w[ST_HOLD_BIT] = s.hold;
    status_word = w;
  endfunction

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    logic cnt_edge;
    logic term;
    logic [31:0] ctrl_word;
    cnt_edge = 1'b0;
    term = 1'b0;
    ctrl_word = 32'h0000_0000;
    st_nxt = st_r;

    // two-stage pin synchroniser; only stage two is looked at
    st_nxt.sync1 = pins;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.clk_prev = st_r.sync2.count_clk;
    cnt_edge = st_r.sync2.count_clk && !st_r.clk_prev;

    // enable and direction are taken as they stand at the detected edge
    if (cnt_edge && !st_r.sync2.count_enable_n && !st_r.hold) begin
      if (st_r.sync2.direction) begin
        st_nxt.count = st_r.count - CNT_ONE;
      end else begin
        st_nxt.count = st_r.count + CNT_ONE;
      end
    end

    // write channel: address and data taken in either order
    if (axi_req.awvalid && st_r.rsp.awready) begin
      st_nxt.aw_done = 1'b1;
      st_nxt.waddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_r.rsp.wready) begin
      st_nxt.w_done = 1'b1;
      st_nxt.wdata = axi_req.wdata;
      st_nxt.wstrb = axi_req.wstrb;
    end
    if (st_r.rsp.bvalid && axi_req.bready) begin
      st_nxt.rsp.bvalid = 1'b0;
    end
    if (st_nxt.aw_done && st_nxt.w_done && !st_nxt.rsp.bvalid) begin
      st_nxt.aw_done = 1'b0;
      st_nxt.w_done = 1'b0;
      st_nxt.rsp.bvalid = 1'b1;
      st_nxt.rsp.bresp = RESP_OKAY;
      if (st_nxt.waddr[7:2] == ADDR_CTRL[7:2]) begin
        ctrl_word = st_nxt.wdata;
        if (st_nxt.wstrb[0]) begin
          st_nxt.hold = ctrl_word[CTRL_HOLD_BIT];
          // software preset overrides a count edge in the same cycle
          if (ctrl_word[CTRL_LOAD_BIT]) begin
            st_nxt.count = ctrl_word[CTRL_VAL_LSB +: CNT_W];
          end
        end
      end else if (st_nxt.waddr[7:2] == ADDR_STATUS[7:2]) begin
        // status is read-only; write is accepted and dropped
        st_nxt.rsp.bresp = RESP_OKAY;
      end else begin
        st_nxt.rsp.bresp = RESP_SLVERR;
      end
    end
    st_nxt.rsp.awready = !st_nxt.aw_done && !st_nxt.rsp.bvalid;
    st_nxt.rsp.wready = !st_nxt.w_done && !st_nxt.rsp.bvalid;

    // read channel
    if (st_r.rsp.rvalid && axi_req.rready) begin
      st_nxt.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st_r.rsp.arready) begin
      st_nxt.rsp.rvalid = 1'b1;
      st_nxt.rsp.rresp = RESP_OKAY;
      if (axi_req.araddr[7:2] == ADDR_CTRL[7:2]) begin
        st_nxt.rsp.rdata = 32'h0000_0000;
        st_nxt.rsp.rdata[CTRL_HOLD_BIT] = st_r.hold;
      end else if (axi_req.araddr[7:2] == ADDR_STATUS[7:2]) begin
        st_nxt.rsp.rdata = status_word(st_r);
      end else begin
        st_nxt.rsp.rdata = 32'h0000_0000;
        st_nxt.rsp.rresp = RESP_SLVERR;
      end
    end
    st_nxt.rsp.arready = !st_nxt.rsp.rvalid;

    // the load pin is a level: it beats counting and software preset every cycle
    if (!st_r.sync2.load_n) begin
      st_nxt.count = st_r.sync2.load_data;
    end

    // outputs follow the count being stored, so flag and strobe never lag it
    term = term_hit(st_nxt.count, st_r.sync2.direction);
    st_nxt.out.count = st_nxt.count;
    st_nxt.out.max_min = term;
    st_nxt.out.ripple_strobe_n = !(term && !st_r.sync2.count_clk
                                   && !st_r.sync2.count_enable_n);
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign axi_rsp = st_r.rsp;
  assign cnt_out = st_r.out;

endmodule
